// ### verif/power_rail_startup_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_rail_startup_sequencer_bench;
    import rail_seq_pkg::*;
    logic       clk = 0, sys_rst = 1, por_active = 0, power_key_n = 1, alarm_wake = 0;
    logic       external_wake = 0, charger_present = 0, battery_good_level = 1;
    logic       battery_under_level = 1, register_rail_mode = 0, buck_cfg_write = 0;
    logic       want_high = 0, want_low = 0, wd_enable = 0, watchdog_write;
    logic       reference_enable, host_reset_out_n, battery_fault_out, supply_fault_out;
    logic       host_io_release, active_mode;
    logic [2:0] high_rail_enable, low_rail_enable;
    rail_req_t  rail_req, register_rail_req = '0;
    buck_cfg_t  buck_cfg_in = '0, buck_cfg_out;
    buck_cfg_t  tbl [4] = '{10'h000, 10'h1FF, 10'h2A5, 10'h108};
    int         bad_count = 0, num_checks = 0, n;
    always #2 clk = ~clk;
    power_rail_startup_sequencer #(.DEBOUNCE_CYCLES(20), .RESET_DELAY_CYCLES(50),
        .WATCHDOG_CYCLES(200), .STEP_GAP(4)) i_dut (.clk, .sys_rst, .por_active,
        .power_key_n, .alarm_wake, .external_wake, .charger_present, .battery_good_level,
        .battery_under_level, .rail_req, .watchdog_write, .register_rail_mode,
        .register_rail_req, .buck_cfg_write, .buck_cfg_in, .reference_enable,
        .host_reset_out_n, .battery_fault_out, .supply_fault_out, .host_io_release,
        .active_mode, .high_rail_enable, .low_rail_enable, .buck_cfg_out);
    rail_host_model i_host (.clk, .sys_rst, .want_high, .want_low, .wd_enable,
        .host_reset_out_n, .low_rail_enable, .rail_req, .watchdog_write);
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return reference_enable;
            1: return host_reset_out_n;
            2: return supply_fault_out;
            3: return low_rail_enable == 3'h7;
            4: return low_rail_enable == 3'h0;
            5: return high_rail_enable == 3'h0;
            default: return !reference_enable;
        endcase
    endfunction
    // Bounded wait on a settled condition; n holds the cycles it took
    task automatic wait_for(input int sel, input int lim);
        n = 0;
        while (pick(sel) !== 1'b1) begin
            if (n == lim) begin
                bad_count++;
                $display("mismatch at %0t: wait %0h got %0h expected %0h", $time, sel, 0, 1);
                tally_and_finish();
            end
            cyc(1);
            n++;
        end
    endtask
    initial begin
        cyc(3);
        sys_rst = 0;
        check(16'(buck_cfg_out), 16'({1'b0, VSEL_RESET, RAMP_RESET}));
        check({reference_enable, host_reset_out_n, battery_fault_out, supply_fault_out}, 0);
        // Key press under power-on reset is ignored
        por_active = 1;
        power_key_n = 0;
        cyc(30);
        check({reference_enable, host_reset_out_n}, 0);
        power_key_n = 1;
        por_active = 0;
        cyc(4);
        // Short key tap: started, then abandoned after debounce
        power_key_n = 0;
        wait_for(0, 8);
        cyc(3);
        power_key_n = 1;
        wait_for(6, 40);
        check(host_reset_out_n, 0);
        // External wake held but battery weak: no reset release
        battery_good_level = 0;
        external_wake = 1;
        wait_for(0, 8);
        wait_for(6, 40);
        check(host_reset_out_n, 0);
        external_wake = 0;
        battery_good_level = 1;
        // Charger start, battery under-voltage at first, no watchdog write: shutdown
        battery_under_level = 0;
        charger_present = 1;
        wait_for(0, 8);
        wait_for(1, 80);
        check(n >= 50, 1);
        check(battery_fault_out, 0);
        battery_under_level = 1;
        cyc(2);
        check({battery_fault_out, host_io_release}, 2'h3);
        wait_for(6, 220);
        check(host_reset_out_n, 0);
        charger_present = 0;
        // Alarm start, host asks for rails early
        wd_enable = 1;
        want_high = 1;
        want_low = 1;
        alarm_wake = 1;
        wait_for(1, 80);
        check(high_rail_enable, 0);
        alarm_wake = 0;
        wait_for(2, 200);
        check({high_rail_enable, low_rail_enable}, 6'h3F);
        check(active_mode, 1);
        // Sleep and wake of the low group
        want_low = 0;
        wait_for(4, 10);
        check(high_rail_enable, 3'h7);
        want_low = 1;
        wait_for(3, 60);
        // Deep sleep and wake
        want_high = 0;
        want_low = 0;
        wait_for(4, 10);
        wait_for(5, 20);
        want_high = 1;
        want_low = 1;
        wait_for(2, 100);
        check(high_rail_enable, 3'h7);
        // Register control overrides the pins
        register_rail_req = 2'h2;
        register_rail_mode = 1;
        wait_for(4, 10);
        check(high_rail_enable, 3'h7);
        register_rail_req = 2'h3;
        wait_for(3, 40);
        register_rail_mode = 0;
        // Buck voltage, ramp and memory setting, including range ends
        foreach (tbl[i]) begin
            buck_cfg_in = tbl[i];
            buck_cfg_write = 1;
            cyc(1);
            buck_cfg_write = 0;
            cyc(2);
            check(16'(buck_cfg_out), 16'(tbl[i]));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### verif/power_rail_startup_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module power_rail_startup_sequencer_monitor
    import rail_seq_pkg::*;
#(
    parameter longint unsigned DEBOUNCE_CYCLES    = DEBOUNCE_CYC,
    parameter longint unsigned RESET_DELAY_CYCLES = RESET_DELAY_CYC,
    parameter longint unsigned WATCHDOG_CYCLES    = WATCHDOG_CYC
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       por_active,
    input wire logic       battery_under_level,
    input wire rail_req_t  rail_req,
    input wire logic       register_rail_mode,
    input wire logic       reference_enable,
    input wire logic       host_reset_out_n,
    input wire logic       battery_fault_out,
    input wire logic       supply_fault_out,
    input wire logic       host_io_release,
    input wire logic       active_mode,
    input wire logic [2:0] high_rail_enable,
    input wire logic [2:0] low_rail_enable
);
    longint unsigned ref_cnt_reg;
    longint unsigned wd_cnt_reg;
    // Run lengths of reference-on and of waiting for the first watchdog write
    always_ff @(posedge clk) begin
        ref_cnt_reg <= (sys_rst || !reference_enable) ? 64'h0 : ref_cnt_reg + 64'h1;
        wd_cnt_reg <= (sys_rst || !host_reset_out_n || active_mode) ? 64'h0 : wd_cnt_reg + 64'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_IO_FIRST: assert property ((|high_rail_enable[2:1]) |-> high_rail_enable[HV_IO_BIT])
        else $error("high rail on without the I/O rail");
    AST_BUCK_FIRST: assert property ((|low_rail_enable[2:1]) |-> low_rail_enable[LV_BUCK_BIT])
        else $error("low rail on without the buck");
    AST_IO_AFTER_RESET: assert property (host_io_release || $rose(|high_rail_enable) |-> host_reset_out_n)
        else $error("host side released while host reset low");
    AST_POR_HOLD: assert property (por_active && !reference_enable |=> !reference_enable)
        else $error("start-up under power-on reset");
    AST_REF_FIRST: assert property (host_reset_out_n || $rose(|low_rail_enable) |-> reference_enable)
        else $error("start-up step without reference");
    AST_RESET_DELAY: assert property ($rose(host_reset_out_n) |-> ref_cnt_reg >= RESET_DELAY_CYCLES - 1)
        else $error("host reset released too early");
    AST_DEBOUNCE_MIN: assert property ($fell(reference_enable) |-> ref_cnt_reg >= DEBOUNCE_CYCLES)
        else $error("start-up abandoned before debounce end");
    AST_WD_WINDOW: assert property (wd_cnt_reg <= WATCHDOG_CYCLES + 2)
        else $error("no shutdown after missing watchdog write");
    AST_SUPPLY_OK: assert property ($rose(supply_fault_out) |->
        $past(high_rail_enable) == 3'h7 && $past(low_rail_enable) == 3'h7 && host_reset_out_n)
        else $error("supply fault released early");
    AST_BATT_OK: assert property ($rose(battery_fault_out) |-> $past(battery_under_level) && reference_enable)
        else $error("battery fault released without cause");
    AST_LOW_OFF: assert property ((!rail_req.low_rail && !register_rail_mode) [*6] |=> low_rail_enable == 3'h0)
        else $error("low rails still on");
    AST_HIGH_OFF: assert property ((!rail_req.high_rail && !register_rail_mode) [*8] |=> high_rail_enable == 3'h0)
        else $error("high rails still on");
    // Main paths: full boot, watchdog hand-over, abandoned start
    cover property ($rose(supply_fault_out));
    cover property ($rose(active_mode));
    cover property ($fell(reference_enable) && !host_reset_out_n);
endmodule
bind power_rail_startup_sequencer power_rail_startup_sequencer_monitor #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES),
    .WATCHDOG_CYCLES(WATCHDOG_CYCLES)) i_mon (.clk, .sys_rst, .por_active, .battery_under_level,
    .rail_req, .register_rail_mode, .reference_enable, .host_reset_out_n, .battery_fault_out,
    .supply_fault_out, .host_io_release, .active_mode, .high_rail_enable, .low_rail_enable);
`default_nettype wire

// ### verif/rail_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Application processor side: rail requests and the first watchdog write
module rail_host_model #(
    parameter int LOW_GAP  = 30,
    parameter int WD_DELAY = 8
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                want_high,
    input  wire logic                want_low,
    input  wire logic                wd_enable,
    input  wire logic                host_reset_out_n,
    input  wire logic [2:0]          low_rail_enable,
    output var rail_seq_pkg::rail_req_t rail_req,
    output var logic                 watchdog_write
);
    int   gap_cnt;
    int   wd_cnt;
    logic wd_done;
    initial begin
        rail_req = '0;
        watchdog_write = 1'b0;
    end
    // Driven on the falling edge so the device samples settled levels
    always @(negedge clk) begin
        watchdog_write <= 1'b0;
        if (sys_rst || !host_reset_out_n) begin
            wd_cnt <= 0;
            wd_done <= 1'b0;
        end else if (wd_enable && !wd_done) begin
            wd_cnt <= wd_cnt + 1;
            if (wd_cnt == WD_DELAY) begin
                watchdog_write <= 1'b1;
                wd_done <= 1'b0 | 1'b1;
            end
        end
        // High request drops only once the low group is fully off
        if (want_high) begin
            rail_req.high_rail <= 1'b1;
        end else if (!rail_req.low_rail && low_rail_enable == 3'h0) begin
            rail_req.high_rail <= 1'b0;
        end
        gap_cnt <= rail_req.high_rail ? gap_cnt + 1 : 0;
        rail_req.low_rail <= want_low && want_high && gap_cnt >= LOW_GAP;
    end
endmodule
`default_nettype wire

// ### verilog/power_rail_startup_sequencer.sv
// Summary of operation
// - Switch-on with no power-on reset enables reference and oscillator first.
// - Switch-on gone after debounce interval: abandon start-up, back to power-down.
// - Switch-on still present after debounce: check battery-good level.
// - Battery good: release host reset at least 50 ms after start.
// - Battery above under-voltage level: raise battery fault output.
// - High-rail request: I/O rail regulator first, then other high rails.
// - Low-rail request: buck first, then other low-voltage regulators.
// - All host supplies stable: raise supply fault output.
// - No watchdog write within window: shut down to power-down.
// - Host-facing requests and interface released only after host reset rises.
// - Low-rail request falls: low rails off within 100 ms.
// - High-rail request falls: high rails off, I/O rail last.
// - Leaving sleep: rising low-rail request re-enables buck and low rails.
// - Leaving deep sleep: I/O rail first, all high rails within 100 ms.
// - Rails follow request pins by default, or register control optionally.
// - Buck voltage 0.85 V to 1.625 V in 25 mV steps, or memory setting.
// - Buck ramp rate set by a four-bit field.
// - Switch-on: key falling, alarm or external wake rising, or charger.
// - Under power-on reset: stay down, ignore switch-on, hold host reset low.
`timescale 1ns/1ps
`default_nettype none
module power_rail_startup_sequencer
    import rail_seq_pkg::*;
#(
    parameter longint unsigned DEBOUNCE_CYCLES    = DEBOUNCE_CYC,
    parameter longint unsigned RESET_DELAY_CYCLES = RESET_DELAY_CYC,
    parameter longint unsigned WATCHDOG_CYCLES    = WATCHDOG_CYC,
    parameter int unsigned     STEP_GAP           = STEP_GAP_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   por_active,
    input  wire logic                   power_key_n,
    input  wire logic                   alarm_wake,
    input  wire logic                   external_wake,
    input  wire logic                   charger_present,
    input  wire logic                   battery_good_level,
    input  wire logic                   battery_under_level,
    input  wire rail_seq_pkg::rail_req_t rail_req,
    input  wire logic                   watchdog_write,
    input  wire logic                   register_rail_mode,
    input  wire rail_seq_pkg::rail_req_t register_rail_req,
    input  wire logic                   buck_cfg_write,
    input  wire rail_seq_pkg::buck_cfg_t buck_cfg_in,
    output logic                        reference_enable,
    output logic                        host_reset_out_n,
    output logic                        battery_fault_out,
    output logic                        supply_fault_out,
    output logic                        host_io_release,
    output logic                        active_mode,
    output logic [2:0]                  high_rail_enable,
    output logic [2:0]                  low_rail_enable,
    output rail_seq_pkg::buck_cfg_t     buck_cfg_out
);
    import rail_seq_pkg::*;

    // Synchronised inputs
    logic key_n_s;
    logic alarm_s;
    logic ext_s;
    logic chg_s;
    logic high_s;
    logic low_s;

    sync_bit u_sync_key (.clk(clk), .sys_rst(sys_rst), .din(power_key_n), .dout(key_n_s));
    sync_bit u_sync_alm (.clk(clk), .sys_rst(sys_rst), .din(alarm_wake), .dout(alarm_s));
    sync_bit u_sync_ext (.clk(clk), .sys_rst(sys_rst), .din(external_wake), .dout(ext_s));
    sync_bit u_sync_chg (.clk(clk), .sys_rst(sys_rst), .din(charger_present), .dout(chg_s));
    sync_bit u_sync_hi  (.clk(clk), .sys_rst(sys_rst), .din(rail_req.high_rail), .dout(high_s));
    sync_bit u_sync_lo  (.clk(clk), .sys_rst(sys_rst), .din(rail_req.low_rail), .dout(low_s));

    typedef struct packed {
        seq_state_t  state;
        logic [39:0] timer;
        logic [39:0] since_on;
        logic        key_n_d;
        logic        alarm_d;
        logic        ext_d;
        logic        chg_d;
        logic        ref_en;
        logic        rst_n;
        logic        batt_ok;
        logic        supply_ok;
        logic        io_rel;
        logic        active;
        logic        hv_req;
        logic        lv_req;
        logic [2:0]  hv_en;
        logic [2:0]  lv_en;
        buck_cfg_t   buck;
    } seq_t;

    seq_t s_reg;
    seq_t s_next;

    logic       on_event;
    logic       still_on;
    logic       hv_req_src;
    logic       lv_req_src;
    logic [2:0] hv_en_w;
    logic [2:0] lv_en_w;
    logic       hv_all;
    logic       lv_all;

    // Any of the four wake sources counts as switch-on
    assign on_event = (s_reg.key_n_d && !key_n_s) || (!s_reg.alarm_d && alarm_s) ||
                      (!s_reg.ext_d && ext_s) || (!s_reg.chg_d && chg_s);
    assign still_on = !key_n_s || alarm_s || ext_s || chg_s;

    // Pin control by default, register control as an option
    assign hv_req_src = register_rail_mode ? register_rail_req.high_rail : high_s;
    assign lv_req_src = register_rail_mode ? register_rail_req.low_rail  : low_s;

    // High group: I/O rail is bit 0, on first and off last
    rail_group #(
        .N              (HV_N),
        .GAP            (STEP_GAP),
        .FIRST_LAST_OFF (1'b1)
    ) u_high (
        .clk     (clk),
        .sys_rst (sys_rst),
        .request (s_reg.hv_req),
        .enable  (hv_en_w),
        .all_on  (hv_all)
    );

    // Low group: buck is bit 0, on first, all off together
    rail_group #(
        .N              (LV_N),
        .GAP            (STEP_GAP),
        .FIRST_LAST_OFF (1'b0)
    ) u_low (
        .clk     (clk),
        .sys_rst (sys_rst),
        .request (s_reg.lv_req),
        .enable  (lv_en_w),
        .all_on  (lv_all)
    );

    // Sequencer next state
    always_comb begin
        s_next          = s_reg;
        s_next.key_n_d  = key_n_s;
        s_next.alarm_d  = alarm_s;
        s_next.ext_d    = ext_s;
        s_next.chg_d    = chg_s;
        s_next.hv_en    = hv_en_w;
        s_next.lv_en    = lv_en_w;
        if (s_reg.since_on != 40'hFF_FFFF_FFFF) begin
            s_next.since_on = s_reg.since_on + 40'h1;
        end
        if (s_reg.timer != 40'h0) begin
            s_next.timer = s_reg.timer - 40'h1;
        end

        // Buck programming is stored as written; memory mode and the code are passed out unchanged
        if (buck_cfg_write) begin
            s_next.buck = buck_cfg_in;
        end

        // Rail requests only honoured while host-facing pins are released
        s_next.hv_req = s_reg.io_rel && hv_req_src;
        s_next.lv_req = s_reg.io_rel && lv_req_src;

        case (s_reg.state)
            ST_POWER_DOWN: begin
                s_next.ref_en    = 1'b0;
                s_next.rst_n     = 1'b0;
                s_next.batt_ok   = 1'b0;
                s_next.supply_ok = 1'b0;
                s_next.io_rel    = 1'b0;
                s_next.active    = 1'b0;
                s_next.hv_req    = 1'b0;
                s_next.lv_req    = 1'b0;
                if (!por_active && on_event) begin
                    s_next.ref_en   = 1'b1;
                    s_next.timer    = 40'(DEBOUNCE_CYCLES);
                    s_next.since_on = 40'h0;
                    s_next.state    = ST_DEBOUNCE;
                end
            end
            ST_DEBOUNCE: begin
                if (s_reg.timer == 40'h0) begin
                    if (still_on) begin
                        s_next.state = ST_BATT_CHECK;
                    end else begin
                        s_next.state = ST_POWER_DOWN;
                    end
                end
            end
            ST_BATT_CHECK: begin
                if (battery_good_level) begin
                    s_next.state = ST_RESET_WAIT;
                end else begin
                    s_next.state = ST_POWER_DOWN;
                end
            end
            ST_RESET_WAIT: begin
                // Counted from start-up, never earlier than the minimum delay
                if (s_reg.since_on >= 40'(RESET_DELAY_CYCLES)) begin
                    s_next.rst_n  = 1'b1;
                    s_next.io_rel = 1'b1;
                    s_next.timer  = 40'(WATCHDOG_CYCLES);
                    s_next.state  = ST_WD_WAIT;
                end
            end
            ST_WD_WAIT: begin
                if (watchdog_write) begin
                    s_next.active = 1'b1;
                    s_next.state  = ST_ACTIVE;
                end else if (s_reg.timer == 40'h0) begin
                    s_next.state = ST_POWER_DOWN;
                end
            end
            ST_ACTIVE: begin
                s_next.state = ST_ACTIVE;
            end
            default: begin
                s_next.state = ST_POWER_DOWN;
            end
        endcase

        // Power-on reset forces power-down and holds the host in reset
        if (por_active) begin
            s_next.state  = ST_POWER_DOWN;
            s_next.rst_n  = 1'b0;
            s_next.io_rel = 1'b0;
            s_next.hv_req = 1'b0;
            s_next.lv_req = 1'b0;
        end

        // Battery flag follows the under-voltage comparator once started
        if (s_reg.state != ST_POWER_DOWN && s_next.state != ST_POWER_DOWN) begin
            s_next.batt_ok = battery_under_level;
            s_next.supply_ok = hv_all && lv_all && s_reg.rst_n;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // Key history starts low like its synchroniser, so no false press follows reset
            s_reg          <= '0;
            s_reg.buck     <= '{memory_mode: 1'b0, voltage_code: VSEL_RESET,
                                ramp_code: RAMP_RESET};
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flops
    assign reference_enable  = s_reg.ref_en;
    assign host_reset_out_n  = s_reg.rst_n;
    assign battery_fault_out = s_reg.batt_ok;
    assign supply_fault_out  = s_reg.supply_ok;
    assign host_io_release   = s_reg.io_rel;
    assign active_mode       = s_reg.active;
    assign high_rail_enable  = s_reg.hv_en;
    assign low_rail_enable   = s_reg.lv_en;
    assign buck_cfg_out      = s_reg.buck;
endmodule
`default_nettype wire

// ### verilog/rail_group.sv
`timescale 1ns/1ps
`default_nettype none
// One regulator group: the first bit switches on first, and off last only with FIRST_LAST_OFF (else all off together)
module rail_group #(
    parameter int unsigned N   = 3,
    parameter int unsigned GAP = 16,
    parameter bit          FIRST_LAST_OFF = 1'b1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         request,
    output logic [N-1:0]      enable,
    output logic              all_on
);
    typedef struct packed {
        logic [N-1:0]  en;
        logic [15:0]   gap;
    } group_state_t;

    group_state_t s_reg;
    group_state_t s_next;

    // Turns on the first regulator, then after one gap all the rest, so inrush is spread out
    always_comb begin
        s_next = s_reg;
        if (!request) begin
            // Off without the gap, even mid-stagger (first bit one cycle after the rest with FIRST_LAST_OFF), so shutdown time never waits on it
            if (FIRST_LAST_OFF && (s_reg.en[N-1:1] != '0)) begin
                s_next.en[N-1:1] = '0;
            end else begin
                s_next.en = '0;
            end
            s_next.gap = 16'h0000;
        end else if (s_reg.gap != 16'h0000) begin
            s_next.gap = s_reg.gap - 16'h0001;
        end else if (s_reg.en != {N{1'b1}}) begin
            if (!s_reg.en[0]) begin
                s_next.en[0] = 1'b1;
            end else begin
                s_next.en = {N{1'b1}};
            end
            s_next.gap = 16'(GAP);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign enable = s_reg.en;
    assign all_on = (s_reg.en == {N{1'b1}}) && (s_reg.gap == 16'h0000);
endmodule
`default_nettype wire

// ### verilog/rail_seq_pkg.sv
package rail_seq_pkg;

    // Clock rate of the internal oscillator domain
    localparam int unsigned CLK_HZ           = 250_000_000;

    // Timing figures in their own units
    localparam int unsigned DEBOUNCE_MS      = 32;
    localparam int unsigned RESET_DELAY_MS   = 50;
    localparam int unsigned WATCHDOG_S       = 8;
    localparam int unsigned SHUTDOWN_MAX_MS  = 100;
    localparam int unsigned HV_STABLE_MS     = 100;

    // Cycle counts derived from the rate (least times round up, longest round down)
    localparam longint unsigned DEBOUNCE_CYC     = (64'(CLK_HZ) * DEBOUNCE_MS + 999) / 1000;
    localparam longint unsigned RESET_DELAY_CYC  = (64'(CLK_HZ) * RESET_DELAY_MS + 999) / 1000;
    localparam longint unsigned WATCHDOG_CYC     = 64'(CLK_HZ) * WATCHDOG_S;
    localparam longint unsigned SHUTDOWN_MAX_CYC = (64'(CLK_HZ) * SHUTDOWN_MAX_MS) / 1000;
    localparam longint unsigned HV_STABLE_CYC    = (64'(CLK_HZ) * HV_STABLE_MS) / 1000;

    // Gap between staggered regulator enables, in cycles
    localparam int unsigned STEP_GAP_CYC     = 16;

    // Buck voltage code: 0.85 V + code * 25 mV, codes 0..31 reach 1.625 V
    localparam int unsigned VSEL_W           = 5;
    localparam logic [4:0]  VSEL_MAX         = 5'h1F;
    localparam logic [4:0]  VSEL_RESET       = 5'h06;
    localparam logic [3:0]  RAMP_RESET       = 4'h0;

    // Regulator enable vector bit positions
    localparam int unsigned HV_IO_BIT        = 0;
    localparam int unsigned HV_N             = 3;
    localparam int unsigned LV_BUCK_BIT      = 0;
    localparam int unsigned LV_N             = 3;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_POWER_DOWN = 3'b000,
        ST_DEBOUNCE   = 3'b001,
        ST_BATT_CHECK = 3'b010,
        ST_RESET_WAIT = 3'b011,
        ST_WD_WAIT    = 3'b100,
        ST_ACTIVE     = 3'b101
    } seq_state_t;

    // Host rail-request pair
    typedef struct packed {
        logic high_rail;
        logic low_rail;
    } rail_req_t;

    // Buck programming carried together
    typedef struct packed {
        logic       memory_mode;
        logic [4:0] voltage_code;
        logic [3:0] ramp_code;
    } buck_cfg_t;

endpackage

// ### verilog/sync_bit.sv
`timescale 1ns/1ps
`default_nettype none
module sync_bit (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);
    logic stage_reg;

    // Two flops; only the second stage is read outside
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage_reg <= 1'b0;
            dout      <= 1'b0;
        end else begin
            stage_reg <= din;
            dout      <= stage_reg;
        end
    end
endmodule
`default_nettype wire
